// >>> logic/debug_hw_command_executor.sv
// Executor of debug hardware commands that steals system bus cycles from the CPU
`timescale 1ns/10ps

module debug_hw_command_executor #(
  parameter int WAIT_LIMIT = debug_cmd_pkg::FREE_WAIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  // Host command side
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic [15:0] cmdAddr,
  input wire logic [15:0] cmdWrData,
  output logic cmdBusy,
  output logic cmdDone,
  output logic [15:0] cmdRdData,
  output logic ackPulse,
  output logic ackEnabled,
  output logic cmdIllegal,
  // Debug mode control
  input wire logic firmwareEnable,
  input wire logic inDebugMode,
  output logic enterDebugReq,
  // System bus shared with the CPU
  input wire logic cpuBusIdle,
  input wire logic busReady,
  input wire logic [15:0] busRdData,
  output logic busReq,
  output logic busWrite,
  output logic [15:0] busAddr,
  output logic [15:0] busWrData,
  output logic [1:0] busByteEn,
  output logic debugTableMapped,
  output logic cpuFreeze
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  debug_cmd_pkg::exec_state_e state_r, state_nxt;
  logic [7:0] waitCnt_r, waitCnt_nxt;
  logic [7:0] op_r, op_nxt;
  logic [15:0] addr_r, addr_nxt;
  logic [15:0] wdata_r, wdata_nxt;
  logic [15:0] rdData_r, rdData_nxt;
  logic ackEn_r, ackEn_nxt;
  logic ackPulse_r, ackPulse_nxt;
  logic done_r, done_nxt;
  logic illegal_r, illegal_nxt;
  logic enterReq_r, enterReq_nxt;
  logic pendAck_r, pendAck_nxt;
  logic busReq_r, busReq_nxt;
  logic busWrite_r, busWrite_nxt;
  logic [1:0] byteEn_r, byteEn_nxt;
  logic mapped_r, mapped_nxt;
  logic freeze_r, freeze_nxt;

  // ----------------------------------------------------------------
  // Command decode of the latched opcode
  // ----------------------------------------------------------------
  logic isRead, isWrite, isByte, isMapped, isMem;

  always_comb begin
    isRead = 1'b0;
    isWrite = 1'b0;
    isByte = 1'b0;
    isMapped = 1'b0;
    case (op_r)
      debug_cmd_pkg::OP_RD_BYTE_MAPPED: begin
        isRead = 1'b1;
        isByte = 1'b1;
        isMapped = 1'b1;
      end
      debug_cmd_pkg::OP_RD_WORD_MAPPED: begin
        isRead = 1'b1;
        isMapped = 1'b1;
      end
      debug_cmd_pkg::OP_RD_BYTE: begin
        isRead = 1'b1;
        isByte = 1'b1;
      end
      debug_cmd_pkg::OP_RD_WORD: begin
        isRead = 1'b1;
      end
      debug_cmd_pkg::OP_WR_BYTE_MAPPED: begin
        isWrite = 1'b1;
        isByte = 1'b1;
        isMapped = 1'b1;
      end
      debug_cmd_pkg::OP_WR_WORD_MAPPED: begin
        isWrite = 1'b1;
        isMapped = 1'b1;
      end
      debug_cmd_pkg::OP_WR_BYTE: begin
        isWrite = 1'b1;
        isByte = 1'b1;
      end
      default: begin
        isRead = 1'b0;
      end
    endcase
    isMem = isRead | isWrite;
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    waitCnt_nxt = waitCnt_r;
    op_nxt = op_r;
    addr_nxt = addr_r;
    wdata_nxt = wdata_r;
    rdData_nxt = rdData_r;
    ackEn_nxt = ackEn_r;
    ackPulse_nxt = 1'b0;
    done_nxt = 1'b0;
    illegal_nxt = 1'b0;
    enterReq_nxt = 1'b0;
    pendAck_nxt = pendAck_r;
    busReq_nxt = 1'b0;
    busWrite_nxt = 1'b0;
    byteEn_nxt = 2'b00;
    mapped_nxt = 1'b0;
    freeze_nxt = 1'b0;
    // Acknowledge for entry to debug mode comes when the mode is reached
    if (pendAck_r && inDebugMode) begin
      pendAck_nxt = 1'b0;
      ackPulse_nxt = ackEn_r;
    end
    case (state_r)
      debug_cmd_pkg::ST_IDLE: begin
        if (cmdValid) begin
          op_nxt = cmdOpcode;
          addr_nxt = cmdAddr;
          wdata_nxt = cmdWrData;
          state_nxt = debug_cmd_pkg::ST_WAIT;
          waitCnt_nxt = debug_cmd_pkg::WAIT_CNT_RESET;
        end
      end
      debug_cmd_pkg::ST_WAIT: begin
        if (op_r == debug_cmd_pkg::OP_ENTER_DEBUG) begin
          if (firmwareEnable && !inDebugMode) begin
            enterReq_nxt = 1'b1;
            pendAck_nxt = 1'b1;
          end
          state_nxt = debug_cmd_pkg::ST_DONE;
        end else if (op_r == debug_cmd_pkg::OP_ACK_ENABLE) begin
          ackEn_nxt = 1'b1;
          ackPulse_nxt = 1'b1;
          state_nxt = debug_cmd_pkg::ST_DONE;
        end else if (op_r == debug_cmd_pkg::OP_ACK_DISABLE) begin
          ackEn_nxt = 1'b0;
          state_nxt = debug_cmd_pkg::ST_DONE;
        end else if (!isMem) begin
          illegal_nxt = 1'b1;
          state_nxt = debug_cmd_pkg::ST_DONE;
        end else if (cpuBusIdle || waitCnt_r == 8'(WAIT_LIMIT - 1)) begin
          // Idle flag is notice that the coming bus cycle is free
          // Memory access regardless of debug mode
          busReq_nxt = 1'b1;
          freeze_nxt = !cpuBusIdle;
          busWrite_nxt = isWrite;
          mapped_nxt = isMapped;
          if (isByte) begin
            byteEn_nxt = addr_r[0] ? 2'b01 : 2'b10;
          end else begin
            byteEn_nxt = 2'b11;
          end
          waitCnt_nxt = debug_cmd_pkg::WAIT_CNT_RESET;
          state_nxt = debug_cmd_pkg::ST_ACCESS;
        end else begin
          waitCnt_nxt = waitCnt_r + 8'h01;
        end
      end
      debug_cmd_pkg::ST_ACCESS: begin
        if (busReady) begin
          if (isRead) begin
            if (isByte) begin
              rdData_nxt = addr_r[0] ? {8'h00, busRdData[7:0]}
                                     : {busRdData[15:8], 8'h00};
            end else begin
              rdData_nxt = busRdData;
            end
          end
          state_nxt = debug_cmd_pkg::ST_DONE;
        end else begin
          // Access stretched past one cycle: CPU stays frozen until it ends
          busReq_nxt = 1'b1;
          busWrite_nxt = busWrite_r;
          byteEn_nxt = byteEn_r;
          mapped_nxt = mapped_r;
          freeze_nxt = 1'b1;
          state_nxt = debug_cmd_pkg::ST_ACCESS;
        end
      end
      debug_cmd_pkg::ST_DONE: begin
        done_nxt = 1'b1;
        if (isMem && ackEn_r) begin
          ackPulse_nxt = 1'b1;
        end
        state_nxt = debug_cmd_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = debug_cmd_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= debug_cmd_pkg::ST_IDLE;
      waitCnt_r <= debug_cmd_pkg::WAIT_CNT_RESET;
      op_r <= 8'h00;
      addr_r <= debug_cmd_pkg::DATA_RESET;
      wdata_r <= debug_cmd_pkg::DATA_RESET;
      rdData_r <= debug_cmd_pkg::DATA_RESET;
      ackEn_r <= debug_cmd_pkg::ACK_EN_RESET;
      ackPulse_r <= 1'b0;
      done_r <= 1'b0;
      illegal_r <= 1'b0;
      enterReq_r <= 1'b0;
      pendAck_r <= 1'b0;
      busReq_r <= 1'b0;
      busWrite_r <= 1'b0;
      byteEn_r <= 2'b00;
      mapped_r <= 1'b0;
      freeze_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      waitCnt_r <= waitCnt_nxt;
      op_r <= op_nxt;
      addr_r <= addr_nxt;
      wdata_r <= wdata_nxt;
      rdData_r <= rdData_nxt;
      ackEn_r <= ackEn_nxt;
      ackPulse_r <= ackPulse_nxt;
      done_r <= done_nxt;
      illegal_r <= illegal_nxt;
      enterReq_r <= enterReq_nxt;
      pendAck_r <= pendAck_nxt;
      busReq_r <= busReq_nxt;
      busWrite_r <= busWrite_nxt;
      byteEn_r <= byteEn_nxt;
      mapped_r <= mapped_nxt;
      freeze_r <= freeze_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Busy flag, registered so the port comes straight from a flip-flop
  // ----------------------------------------------------------------
  logic busy_r, busy_nxt;

  always_comb begin
    busy_nxt = (state_nxt != debug_cmd_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= busy_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cmdBusy = busy_r;
  assign cmdDone = done_r;
  assign cmdRdData = rdData_r;
  assign ackPulse = ackPulse_r;
  assign ackEnabled = ackEn_r;
  assign cmdIllegal = illegal_r;
  assign enterDebugReq = enterReq_r;
  assign busReq = busReq_r;
  assign busWrite = busWrite_r;
  assign busAddr = addr_r;
  assign busWrData = wdata_r;
  assign busByteEn = byteEn_r;
  assign debugTableMapped = mapped_r;
  assign cpuFreeze = freeze_r;

endmodule : debug_hw_command_executor

// >>> logic/debug_cmd_pkg.sv
// Package: opcodes, states and timing constants of the debug hardware command executor
package debug_cmd_pkg;

  // ----------------------------------------------------------------
  // Command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_ENTER_DEBUG = 8'h90;
  localparam logic [7:0] OP_ACK_ENABLE = 8'hd5;
  localparam logic [7:0] OP_ACK_DISABLE = 8'hd6;
  localparam logic [7:0] OP_RD_BYTE_MAPPED = 8'he4;
  localparam logic [7:0] OP_RD_WORD_MAPPED = 8'hec;
  localparam logic [7:0] OP_RD_BYTE = 8'he0;
  localparam logic [7:0] OP_RD_WORD = 8'he8;
  localparam logic [7:0] OP_WR_BYTE_MAPPED = 8'hc4;
  localparam logic [7:0] OP_WR_WORD_MAPPED = 8'hcc;
  localparam logic [7:0] OP_WR_BYTE = 8'hc0;

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int FREE_WAIT_CYCLES = 128;
  localparam logic [7:0] WAIT_CNT_RESET = 8'h00;
  localparam logic ACK_EN_RESET = 1'b0;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Executor states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_WAIT = 5'b00010,
    ST_ACCESS = 5'b00100,
    ST_HOLD = 5'b01000,
    ST_DONE = 5'b10000
  } exec_state_e;

endpackage : debug_cmd_pkg

// >>> tb/debug_hw_command_executor_props.sv
// Checker of bus stealing, lane and handshake timing of the command executor
`timescale 1ns/10ps
module debug_hw_command_executor_props #(
  parameter int WAIT_LIMIT = 128
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmdValid,
  input wire logic [7:0] cmdOpcode,
  input wire logic cmdBusy,
  input wire logic cmdDone,
  input wire logic ackPulse,
  input wire logic cpuBusIdle,
  input wire logic busReady,
  input wire logic busReq,
  input wire logic [15:0] busAddr,
  input wire logic [1:0] busByteEn,
  input wire logic debugTableMapped,
  input wire logic cpuFreeze
);
  // ----
  // Cycles spent busy without the bus
  // ----
  logic [9:0] waitCnt_r;
  logic [9:0] waitCnt_nxt;
  logic take;
  assign take = cmdValid && !cmdBusy;
  always_comb begin
    waitCnt_nxt = (cmdBusy && !busReq) ? waitCnt_r + 10'h001 : 10'h000;
  end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      waitCnt_r <= 10'h000;
    end else begin
      waitCnt_r <= waitCnt_nxt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wait_bound_a: assert property (waitCnt_r <= 10'(WAIT_LIMIT + 3))
    else $error("debug access waited too long");
  forced_frz_a: assert property ($rose(busReq) && !$past(cpuBusIdle) |-> cpuFreeze)
    else $error("stolen cycle without freeze");
  steal_wait_a: assert property ($rose(busReq) && !$past(cpuBusIdle)
    |-> waitCnt_r == 10'(WAIT_LIMIT))
    else $error("cycle stolen before the wait ran out");
  free_nofrz_a: assert property ($rose(busReq) && $past(cpuBusIdle) && busReady
    |-> !cpuFreeze)
    else $error("free single cycle froze the cpu");
  stretch_frz_a: assert property (busReq && !busReady
    |=> busReq && cpuFreeze && $stable(busAddr))
    else $error("stretched access not frozen");
  done_lat_a: assert property (busReq && busReady |-> ##2 cmdDone)
    else $error("done not two cycles after access");
  map_cycle_a: assert property (debugTableMapped |-> busReq)
    else $error("debug table mapped outside access");
  lane_sel_a: assert property (busReq && busByteEn != 2'h3
    |-> busByteEn == (busAddr[0] ? 2'h1 : 2'h2))
    else $error("wrong byte lane");
  ack_off_a: assert property (take && cmdOpcode == debug_cmd_pkg::OP_ACK_DISABLE
    |=> !ackPulse [*4])
    else $error("pulse after handshake disable");
  ack_on_a: assert property (take && cmdOpcode == debug_cmd_pkg::OP_ACK_ENABLE
    |-> ##[1:4] ackPulse)
    else $error("no pulse after handshake enable");
endmodule : debug_hw_command_executor_props

bind debug_hw_command_executor debug_hw_command_executor_props #(.WAIT_LIMIT(WAIT_LIMIT)) i_props (
  .mclk, .rst, .cmdValid, .cmdOpcode, .cmdBusy, .cmdDone, .ackPulse, .cpuBusIdle, .busReady,
  .busReq, .busAddr, .busByteEn, .debugTableMapped, .cpuFreeze);

// >>> tb/bus_memory_model.sv
// System bus memory with a debug table and a settable answer delay
`timescale 1ns/10ps
module bus_memory_model (
  input wire logic mclk,
  input wire logic busReq,
  input wire logic busWrite,
  input wire logic [15:0] busAddr,
  input wire logic [15:0] busWrData,
  input wire logic [1:0] busByteEn,
  input wire logic debugTableMapped,
  input wire logic [1:0] delay,
  output logic busReady,
  output logic [15:0] busRdData
);
  // Plane 1 is the debug table, reachable only while mapped in
  logic [15:0] mem [2][256] = '{default: 16'h0000};
  logic [1:0] cnt = 2'h0;
  logic tog = 1'b0;
  assign busReady = busReq && cnt == delay;
  // Idle data lines toggle so a stray sample never matches
  assign busRdData = busReady ? mem[debugTableMapped][busAddr[8:1]] : {16{tog}};
  always @(posedge mclk) begin
    tog <= ~tog;
    cnt <= (busReq && !busReady) ? cnt + 2'h1 : 2'h0;
    if (busReady && busWrite && busByteEn[1]) begin
      mem[debugTableMapped][busAddr[8:1]][15:8] <= busWrData[15:8];
    end
    if (busReady && busWrite && busByteEn[0]) begin
      mem[debugTableMapped][busAddr[8:1]][7:0] <= busWrData[7:0];
    end
  end
endmodule : bus_memory_model

// >>> tb/debug_hw_command_executor_tb.sv
// Self-checking bench of the debug command executor
`timescale 1ns/10ps
module debug_hw_command_executor_tb;
  logic mclk, rst, cmdValid, cmdBusy, cmdDone, ackPulse, ackEnabled, cmdIllegal, firmwareEnable;
  logic inDebugMode, enterDebugReq, cpuBusIdle, busReady, busReq, busWrite, debugTableMapped;
  logic cpuFreeze, sawAck, sawFrz, sawEnter, sawIll, sawBusy;
  logic [7:0] cmdOpcode;
  logic [15:0] cmdAddr, cmdWrData, cmdRdData, busRdData, busAddr, busWrData;
  logic [1:0] busByteEn, delay;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;
  debug_hw_command_executor #(.WAIT_LIMIT(4)) i_debug_hw_command_executor (.mclk, .rst,
    .cmdValid, .cmdOpcode, .cmdAddr, .cmdWrData, .cmdBusy, .cmdDone, .cmdRdData, .ackPulse,
    .ackEnabled, .cmdIllegal, .firmwareEnable, .inDebugMode, .enterDebugReq, .cpuBusIdle,
    .busReady, .busRdData, .busReq, .busWrite, .busAddr, .busWrData, .busByteEn,
    .debugTableMapped, .cpuFreeze);
  bus_memory_model i_bus_memory_model (.mclk, .busReq, .busWrite, .busAddr, .busWrData,
    .busByteEn, .debugTableMapped, .delay, .busReady, .busRdData);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // ----
  // One command, taken at a rising edge, watched until done
  // ----
  task automatic run(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
    @(negedge mclk);
    {cmdOpcode, cmdAddr, cmdWrData, cmdValid} = {op, a, d, 1'b1};
    {sawAck, sawFrz, sawEnter, sawIll, sawBusy} = 5'b00000;
    for (int n = 0; n < 300 && cmdDone !== 1'b1; n++) begin
      @(negedge mclk);
      cmdValid = 1'b0;
      sawAck |= ackPulse === 1'b1;
      sawFrz |= cpuFreeze === 1'b1;
      sawEnter |= enterDebugReq === 1'b1;
      sawIll |= cmdIllegal === 1'b1;
      sawBusy |= cmdBusy === 1'b1;
    end
    chk({14'h0, sawBusy, cmdDone}, 16'h0003);
    @(negedge mclk);
  endtask : run
  task automatic t_ack;
    run(debug_cmd_pkg::OP_ACK_ENABLE, 16'h0000, 16'h0000);
    chk({14'h0, ackEnabled, sawAck}, 16'h0003);
    run(debug_cmd_pkg::OP_RD_WORD, 16'h0010, 16'h0000);
    chk({15'h0, sawAck}, 16'h0001);
    run(8'h00, 16'h0010, 16'h0000);
    chk({14'h0, sawIll, sawAck}, 16'h0002);
    run(debug_cmd_pkg::OP_ACK_DISABLE, 16'h0000, 16'h0000);
    chk({14'h0, ackEnabled, sawAck}, 16'h0000);
    $display("test handshake done");
  endtask : t_ack
  task automatic t_mem;
    run(debug_cmd_pkg::OP_WR_BYTE, 16'h0011, 16'h00ab);
    run(debug_cmd_pkg::OP_WR_BYTE, 16'h0010, 16'hcd00);
    run(debug_cmd_pkg::OP_RD_WORD, 16'h0010, 16'h0000);
    chk(cmdRdData, 16'hcdab);
    run(debug_cmd_pkg::OP_RD_BYTE, 16'h0011, 16'h0000);
    chk(cmdRdData, 16'h00ab);
    run(debug_cmd_pkg::OP_RD_BYTE, 16'h0010, 16'h0000);
    chk(cmdRdData, 16'hcd00);
    run(debug_cmd_pkg::OP_WR_WORD_MAPPED, 16'h0010, 16'h1234);
    run(debug_cmd_pkg::OP_WR_BYTE_MAPPED, 16'h0011, 16'h0077);
    run(debug_cmd_pkg::OP_RD_WORD_MAPPED, 16'h0010, 16'h0000);
    chk(cmdRdData, 16'h1277);
    run(debug_cmd_pkg::OP_RD_BYTE_MAPPED, 16'h0010, 16'h0000);
    chk(cmdRdData, 16'h1200);
    run(debug_cmd_pkg::OP_RD_WORD, 16'h0010, 16'h0000);
    chk(cmdRdData, 16'hcdab);
    $display("test memory done");
  endtask : t_mem
  task automatic t_frz(input logic idle, input logic [1:0] dly, input logic exp,
                       input logic [15:0] d);
    @(negedge mclk);
    {cpuBusIdle, delay} = {idle, dly};
    run(debug_cmd_pkg::OP_WR_WORD_MAPPED, 16'h0020, d);
    chk({15'h0, sawFrz}, {15'h0, exp});
    run(debug_cmd_pkg::OP_RD_WORD_MAPPED, 16'h0020, 16'h0000);
    chk(cmdRdData, d);
    chk({15'h0, sawFrz}, {15'h0, exp});
    {cpuBusIdle, delay} = 3'b100;
    $display("test freeze done");
  endtask : t_frz
  task automatic t_enter(input logic fw, input logic [15:0] d);
    logic ack;
    run(debug_cmd_pkg::OP_ACK_ENABLE, 16'h0000, 16'h0000);
    firmwareEnable = fw;
    run(debug_cmd_pkg::OP_ENTER_DEBUG, 16'h0000, 16'h0000);
    chk({14'h0, sawEnter, sawAck}, {14'h0, fw, 1'b0});
    inDebugMode = 1'b1;
    ack = 1'b0;
    repeat (3) begin
      @(negedge mclk);
      ack |= ackPulse === 1'b1;
    end
    chk({15'h0, ack}, {15'h0, fw});
    run(debug_cmd_pkg::OP_WR_BYTE, 16'h0031, d);
    run(debug_cmd_pkg::OP_RD_WORD, 16'h0030, 16'h0000);
    chk(cmdRdData, {8'h00, d[7:0]});
    run(debug_cmd_pkg::OP_ACK_DISABLE, 16'h0000, 16'h0000);
    inDebugMode = 1'b0;
    $display("test enter done");
  endtask : t_enter
  task automatic finish_test;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : finish_test
  initial begin
    {rst, cmdValid, cmdOpcode, cmdAddr, cmdWrData, firmwareEnable, inDebugMode} = '0;
    {cpuBusIdle, delay} = 3'b100;
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    t_ack();
    t_mem();
    t_frz(1'b1, 2'h0, 1'b0, 16'h3c3c);
    t_frz(1'b0, 2'h0, 1'b1, 16'hc3c3);
    t_frz(1'b1, 2'h2, 1'b1, 16'h5a96);
    t_enter(1'b0, 16'h0042);
    t_enter(1'b1, 16'h0099);
    finish_test();
  end
endmodule : debug_hw_command_executor_tb
